// ===== satr_pkg.sv
// Package of constants and types for the skip and table read unit
package satr_pkg;
    // Data and program word widths
    localparam int DATA_W = 8;
    localparam int ROM_W = 16;
    localparam int ROM_AW = 12;
    localparam int PAGE_W = 4;
    localparam int PTR_W = 8;
    // High latch width: upper part of the program word
    localparam int HIGH_W = 8;
    // Index of the final program page
    localparam logic [PAGE_W-1:0] FINAL_PAGE = 4'hf;
    // Reset values
    localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
    localparam logic [HIGH_W-1:0] HIGH_RST = 8'h00;
    // Table read takes one fetch cycle before its write lands
    localparam int TABLE_WAIT_CYC = 1;
    // Operation selector
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_LOAD_SKIP = 3'h1;
    localparam logic [2:0] OP_BIT_SKIP = 3'h2;
    localparam logic [2:0] OP_TAB_CUR = 3'h3;
    localparam logic [2:0] OP_TAB_FIN = 3'h4;
    // Sequencer states
    typedef enum logic [1:0] {SATR_IDLE, SATR_DUMMY, SATR_TABLE} satr_state_e;
endpackage

// ===== satr_rom.sv
// Program memory model with registered read data
`timescale 1ns/1ps
module satr_rom
(
    // Clock
    input wire logic clk,
    // Read port
    input wire logic [satr_pkg::ROM_AW-1:0] rd_addr,
    output logic [satr_pkg::ROM_W-1:0] rd_data,
    // Load port
    input wire logic wr_en,
    input wire logic [satr_pkg::ROM_AW-1:0] wr_addr,
    input wire logic [satr_pkg::ROM_W-1:0] wr_data
);
    logic [satr_pkg::ROM_W-1:0] mem [0:(1<<satr_pkg::ROM_AW)-1];

    // Load words from the programming side
    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read keeps timing clean at the cost of one cycle
    always_ff @(posedge clk)
    begin
        rd_data <= mem[rd_addr];
    end
endmodule

// ===== satr_core.sv
// Execution unit for conditional skip and table read instructions
// Overview of operation
// - Load skip copies byte into accumulator first
// - True skip discards prefetch, adds dummy cycle
// - False skip finishes in one cycle
// - Bit skip tests bit i for zero
// - Current page read writes low byte
// - High byte goes to high latch
// - Final page read uses last page
`timescale 1ns/1ps
module satr_core
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Instruction issue
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [2:0] bit_index,
    input wire logic [satr_pkg::DATA_W-1:0] mem_rd_data,
    // Table pointer and current page
    input wire logic [satr_pkg::PTR_W-1:0] rom_table_pointer,
    input wire logic [satr_pkg::PAGE_W-1:0] cur_page,
    // Program memory load port
    input wire logic rom_wr_en,
    input wire logic [satr_pkg::ROM_AW-1:0] rom_wr_addr,
    input wire logic [satr_pkg::ROM_W-1:0] rom_wr_data,
    // Results
    output logic [satr_pkg::DATA_W-1:0] acc,
    output logic [satr_pkg::HIGH_W-1:0] rom_table_high_latch,
    output logic mem_wr_en,
    output logic [satr_pkg::DATA_W-1:0] mem_wr_data,
    output logic discard_prefetch,
    output logic busy,
    output logic flags_we
);
    satr_pkg::satr_state_e state_reg;
    logic [satr_pkg::ROM_AW-1:0] rom_addr;
    logic [satr_pkg::ROM_W-1:0] rom_data;
    logic skip_now;
    logic accept;

    // Skip condition decoded once for both skip kinds
    function automatic logic skip_test(input logic [2:0] code,
                                       input logic [7:0] data,
                                       input logic [2:0] idx);
        logic r;
        r = 1'b0;
        case (code)
            satr_pkg::OP_LOAD_SKIP: r = (data == 8'h00);
            satr_pkg::OP_BIT_SKIP: r = ~data[idx];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // New instructions only land when the sequencer is idle
    assign accept = op_valid && (state_reg == satr_pkg::SATR_IDLE);
    assign skip_now = accept && skip_test(op_code, mem_rd_data, bit_index);

    always_comb
    begin
        if (op_code == satr_pkg::OP_TAB_FIN)
        begin
            rom_addr = {satr_pkg::FINAL_PAGE, rom_table_pointer};
        end
        else
        begin
            rom_addr = {cur_page, rom_table_pointer};
        end
    end

    satr_rom u_rom
    (
        .clk(clk),
        .rd_addr(rom_addr),
        .rd_data(rom_data),
        .wr_en(rom_wr_en),
        .wr_addr(rom_wr_addr),
        .wr_data(rom_wr_data)
    );

    // Sequencer: dummy cycle after true skip, wait for table data
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= satr_pkg::SATR_IDLE;
        end
        else
        begin
            case (state_reg)
                satr_pkg::SATR_IDLE:
                begin
                    if (skip_now)
                    begin
                        state_reg <= satr_pkg::SATR_DUMMY;
                    end
                    else if (accept && (op_code == satr_pkg::OP_TAB_CUR ||
                             op_code == satr_pkg::OP_TAB_FIN))
                    begin
                        state_reg <= satr_pkg::SATR_TABLE;
                    end
                end
                satr_pkg::SATR_DUMMY: state_reg <= satr_pkg::SATR_IDLE;
                satr_pkg::SATR_TABLE: state_reg <= satr_pkg::SATR_IDLE;
                default: state_reg <= satr_pkg::SATR_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            discard_prefetch <= 1'b0;
        end
        else
        begin
            discard_prefetch <= skip_now;
        end
    end

    // Busy covers the dummy cycle and the table fetch cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            busy <= 1'b0;
        end
        else
        begin
            busy <= skip_now || (accept &&
                    (op_code == satr_pkg::OP_TAB_CUR ||
                     op_code == satr_pkg::OP_TAB_FIN));
        end
    end

    // byte loaded on the same edge as the zero test result acts
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            acc <= satr_pkg::ACC_RST;
        end
        else if (accept && op_code == satr_pkg::OP_LOAD_SKIP)
        begin
            acc <= mem_rd_data;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_wr_en <= 1'b0;
            mem_wr_data <= 8'h00;
        end
        else
        begin
            mem_wr_en <= (state_reg == satr_pkg::SATR_TABLE);
            if (state_reg == satr_pkg::SATR_TABLE)
            begin
                mem_wr_data <= rom_data[7:0];
            end
        end
    end

    // high byte to latch, same edge as low write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rom_table_high_latch <= satr_pkg::HIGH_RST;
        end
        else if (state_reg == satr_pkg::SATR_TABLE)
        begin
            rom_table_high_latch <= rom_data[15:8];
        end
    end

    // status flags never written by this unit
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            flags_we <= 1'b0;
        end
        else
        begin
            flags_we <= 1'b0;
        end
    end
endmodule

// ===== satr_core_asserts.sv
// Assertions for the skip and table read unit
`timescale 1ns/1ps
module satr_core_asserts
(
    // Watched ports
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire logic [2:0] op_code,
    input wire logic [2:0] bit_index,
    input wire logic [7:0] mem_rd_data,
    input wire logic [7:0] acc,
    input wire logic [7:0] rom_table_high_latch,
    input wire logic mem_wr_en,
    input wire logic discard_prefetch,
    input wire logic busy,
    input wire logic flags_we
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // Issue accepted only while idle; skip test result
    wire take = op_valid && !busy;
    wire hit = (op_code == 3'h1 && mem_rd_data == 8'h00) ||
        (op_code == 3'h2 && !mem_rd_data[bit_index]);
    sequence tab_write_s;
        busy ##1 mem_wr_en;
    endsequence
    load_acc_a:
        assert property (take && op_code == 3'h1 |=> acc == $past(mem_rd_data))
        else $error("acc not loaded");
    skip_true_a:
        assert property (take && hit |=> discard_prefetch && busy)
        else $error("true skip missed");
    skip_false_a:
        assert property (take && !hit && op_code inside {3'h1, 3'h2}
            |=> !discard_prefetch && !busy) else $error("false skip stalled");
    table_wait_a:
        assert property (take && op_code inside {3'h3, 3'h4} |=> tab_write_s)
        else $error("table write late");
    latch_hold_a:
        assert property (!mem_wr_en |-> $stable(rom_table_high_latch))
        else $error("latch moved alone");
    bit_acc_a:
        assert property (take && op_code == 3'h2 |=> $stable(acc))
        else $error("bit skip touched acc");
    one_dummy_a:
        assert property (busy |=> !discard_prefetch)
        else $error("extra discard");
    flags_quiet_a:
        assert property (!flags_we) else $error("flags written");
endmodule
bind satr_core satr_core_asserts u_chk (.clk(clk), .rst(rst),
    .op_valid(op_valid), .op_code(op_code), .bit_index(bit_index),
    .mem_rd_data(mem_rd_data), .acc(acc), .mem_wr_en(mem_wr_en),
    .rom_table_high_latch(rom_table_high_latch), .busy(busy),
    .discard_prefetch(discard_prefetch), .flags_we(flags_we));

// ===== tb_satr_core.sv
// Self-checking bench for the skip and table read unit
`timescale 1ns/1ps
module tb_satr_core;
    logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, rom_wr_en = 1'b0;
    logic [2:0] op_code = 3'h0, bit_index = 3'h0;
    logic [7:0] mem_rd_data = 8'h00, rom_table_pointer = 8'h00, acc_m;
    logic [7:0] acc, latch, wdat;
    logic [3:0] cur_page = 4'h0;
    logic [11:0] rom_wr_addr = 12'h000;
    logic [15:0] rom_wr_data = 16'h0000, w;
    logic mem_wr_en, discard_prefetch, busy, flags_we;
    integer errors = 0, samples_checked = 0, seed = 32'h9aa6aba7, i;
    satr_core dut_u (.clk(clk), .rst(rst), .op_valid(op_valid),
        .op_code(op_code), .bit_index(bit_index), .mem_rd_data(mem_rd_data),
        .rom_table_pointer(rom_table_pointer), .cur_page(cur_page),
        .rom_wr_en(rom_wr_en), .rom_wr_addr(rom_wr_addr),
        .rom_wr_data(rom_wr_data), .acc(acc), .rom_table_high_latch(latch),
        .mem_wr_en(mem_wr_en), .mem_wr_data(wdat), .busy(busy),
        .discard_prefetch(discard_prefetch), .flags_we(flags_we));
    // 200 MHz clock
    initial forever #2.5 clk = ~clk;
    task summarize;
        if (errors == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] s);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    function logic hit(logic [2:0] c, logic [7:0] d, logic [2:0] x);
        return (c == 3'h1 && d == 8'h00) || (c == 3'h2 && !d[x]);
    endfunction
    // Every output must read zero while and just after reset holds
    task rst_chk;
        chk("acc", 0, acc);
        chk("high", 0, latch);
        chk("wr", 0, mem_wr_en);
        chk("low", 0, wdat);
        chk("discard", 0, discard_prefetch);
        chk("busy", 0, busy);
        chk("flags", 0, flags_we);
    endtask
    task rom(input logic [11:0] a, input logic [15:0] d);
        @(posedge clk);
        rom_wr_en <= 1'b1;
        rom_wr_addr <= a;
        rom_wr_data <= d;
        @(posedge clk);
        rom_wr_en <= 1'b0;
    endtask
    // Hold keeps op_valid one more cycle: refused or back-to-back issue
    task op(input logic [2:0] c, input logic [7:0] d, input logic [2:0] x,
        input logic hold);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        mem_rd_data <= d;
        bit_index <= x;
        @(posedge clk);
        op_valid <= hold;
        if (c == 3'h1) acc_m = d;
        #1;
        chk("acc", acc_m, acc);
        chk("discard", hit(c, d, x), discard_prefetch);
        chk("flags", 0, flags_we);
        chk("busy", hit(c, d, x) || c > 3'h2, busy);
        chk("wr", 0, mem_wr_en);
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("redo", 0, discard_prefetch);
        chk("busy", 0, busy);
        chk("wr", c > 3'h2, mem_wr_en);
        if (c > 3'h2)
        begin
            chk("low", w[7:0], wdat);
            chk("high", w[15:8], latch);
        end
    endtask
    // Corner cases, then random table reads and skips
    initial
    begin
        acc_m = 8'h00;
        w = 16'h0000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        rst_chk;
        op(3'h1, 8'h00, 3'h0, 1'b1);
        op(3'h1, 8'h01, 3'h0, 1'b1);
        op(3'h2, 8'h7f, 3'h7, 1'b0);
        op(3'h2, 8'h80, 3'h7, 1'b1);
        // No-operation code with a zero byte must never skip
        op(3'h0, 8'h00, 3'h0, 1'b0);
        for (i = 0; i < 40; i++)
        begin
            @(posedge clk);
            cur_page <= 4'($unsigned($random(seed)) % 15);
            rom_table_pointer <= 8'($random(seed));
            w = 16'($random(seed));
            #1;
            rom({cur_page, rom_table_pointer}, w);
            rom({satr_pkg::FINAL_PAGE, rom_table_pointer}, ~w);
            op(3'h3, 8'($random(seed)), 3'h0, i[0]);
            w = ~w;
            op(3'h4, 8'($random(seed)), 3'h0, i[1]);
            op(3'($unsigned($random(seed)) % 2 + 1), 8'($random(seed)),
                3'($random(seed)), i[1]);
        end
        // Mid-run reset: outputs clear at once, then work resumes
        @(posedge clk);
        rst <= 1'b1;
        #1;
        rst_chk;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        acc_m = 8'h00;
        #1;
        rst_chk;
        op(3'h2, 8'hfe, 3'h0, 1'b0);
        op(3'h1, 8'h5a, 3'h0, 1'b0);
        summarize;
    end
endmodule
